// file: design/flash_program_erase_sequencer.sv
// Flash program/erase control: control bits, latches, mode and guard timer.
//
// Behaviour
// - Four modes entered by setup, pulse and verify control bits.
// - Array reads are blocked while program or erase is active.
// - No program or erase unless permit pin high and flag reads one.
// - Each data byte written in idle mode with write permitted is latched; the last write's address is kept for the pulse.
// - Leaving program or erase mode clears the watchdog setting.
// - Verify: wait gamma, dummy write 0xFF, wait epsilon, read 16 bits.
// - Erase needs no preprogramming to zeros.
`timescale 1ns/100ps
module flash_program_erase_sequencer #(
  // Wait times in microseconds (z for erase in ms) and retry limit.
  parameter int T_X_US = 1,
  parameter int T_Y_US = 1,
  parameter int T_Z_US = 1,
  parameter int T_Z_MS = 1,
  parameter int T_ALPHA_US = 1,
  parameter int T_BETA_US = 1,
  parameter int T_GAMMA_US = 1,
  parameter int T_EPS_US = 1,
  parameter int T_ETA_US = 1,
  parameter int RETRY_N = 1000,
  parameter int CLK_MHZ = 200
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_resetn,
  // Write-permit pin and software flag.
  input wire logic i_hardware_write_permit_pin,
  // Control bits of flash_control_reg, as software last wrote them.
  input wire logic i_flash_write_unlock,
  input wire logic i_write_setup,
  input wire logic i_write_pulse,
  input wire logic i_write_check,
  input wire logic i_wipe_setup,
  input wire logic i_wipe_pulse,
  input wire logic i_wiping_audit,
  // Contents of block_select_reg.
  input wire logic [flash_seq_pkg::BLOCKS-1:0] i_block_select_reg,
  // CPU writes to the flash address space.
  input wire logic i_wr_en,
  input wire logic [flash_seq_pkg::ADDR_W-1:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  // CPU reads from the flash address space.
  input wire logic i_rd_en,
  input wire logic [flash_seq_pkg::ADDR_W-1:0] i_rd_addr,
  // Array interface; the array answers reads one cycle later.
  input wire logic [flash_seq_pkg::VDATA_W-1:0] i_array_rdata,
  output logic o_array_rd,
  output logic [flash_seq_pkg::ADDR_W-1:0] o_array_addr,
  output logic o_array_prog,
  output logic o_array_erase,
  output logic [flash_seq_pkg::BLOCKS-1:0] o_array_blocks,
  output logic [7:0] o_latch_data,
  output logic [flash_seq_pkg::UNIT_IDX_W-1:0] o_latch_idx,
  // Answers to the CPU.
  output logic [flash_seq_pkg::VDATA_W-1:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_rd_blocked,
  // Status.
  output logic o_permit_flag,
  output logic [4:0] o_mode,
  output logic o_guard_clear,
  output logic o_pulse_overrun,
  output logic [15:0] o_pass_count,
  output logic o_retry_exhausted,
  output logic o_unit_full
);
  // Per-pulse limits in cycles; longest times round down, never below one.
  localparam int PROG_LIM = (T_Z_US * CLK_MHZ) < 1 ? 1 : T_Z_US * CLK_MHZ;
  localparam int ERASE_LIM =
    (T_Z_MS * 1000 * CLK_MHZ) < 1 ? 1 : T_Z_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 32;

  typedef struct packed {
    logic [1:0] pin_sync;
    logic [4:0] mode;
    logic [flash_seq_pkg::UNIT_IDX_W-1:0] idx;
    logic unit_full;
    logic [flash_seq_pkg::ADDR_W-1:0] vaddr;
    logic [CNT_W-1:0] pulse_cnt;
    logic overrun;
    logic [15:0] passes;
    logic guard_clear;
    logic rd_pend;
    logic rd_chk;
    logic blocked;
    logic [flash_seq_pkg::VDATA_W-1:0] rdata;
    logic rvalid;
  } state_type;

  state_type cur_ff;
  state_type nxt_ff;
  logic permit;
  logic [7:0] latch_q;

  // True in the two modes that drive the array and forbid array reads.
  function automatic logic active_mode(input logic [4:0] m);
    active_mode = (m == flash_seq_pkg::MODE_PROG) ||
                  (m == flash_seq_pkg::MODE_ERASE);
  endfunction : active_mode

  assign permit = cur_ff.pin_sync[1];

  flash_write_latch u_latch (
    .i_clock(i_clock),
    .i_wr_en(i_wr_en && cur_ff.mode == flash_seq_pkg::MODE_IDLE
             && i_flash_write_unlock && permit),
    .i_wr_idx(i_wr_addr[flash_seq_pkg::UNIT_IDX_W-1:0]),
    .i_wr_data(i_wr_data),
    .i_rd_idx(cur_ff.idx),
    .o_rd_data(latch_q)
  );

  // Next-state logic: mode choice, latching, pulse timing and verify reads.
  always_comb begin
    logic [4:0] want;
    want = flash_seq_pkg::MODE_IDLE;
    nxt_ff = cur_ff;
    nxt_ff.pin_sync = {cur_ff.pin_sync[0], i_hardware_write_permit_pin};
    nxt_ff.guard_clear = 1'b0;
    nxt_ff.rvalid = 1'b0;
    nxt_ff.blocked = 1'b0;
    // Mode decode from control bits; pulses need their setup bit.
    if (!(permit && i_flash_write_unlock)) begin
      want = flash_seq_pkg::MODE_IDLE;
    end else if (i_write_setup && i_write_pulse) begin
      want = flash_seq_pkg::MODE_PROG;
    end else if (i_wipe_setup && i_wipe_pulse
                 && $countones(i_block_select_reg) == 1) begin
      want = flash_seq_pkg::MODE_ERASE;
    end else if (i_write_check) begin
      want = flash_seq_pkg::MODE_PCHK;
    end else if (i_wiping_audit) begin
      want = flash_seq_pkg::MODE_ECHK;
    end
    nxt_ff.mode = want;
    // Leaving program or erase clears the guard timer setting.
    if (active_mode(cur_ff.mode) && !active_mode(want)) begin
      nxt_ff.guard_clear = 1'b1;
      nxt_ff.passes = cur_ff.passes + 16'd1;
    end
    // Pulse length guard; the array pulse is cut at the limit.
    if (active_mode(want) && want == cur_ff.mode) begin
      if (!cur_ff.overrun) begin
        nxt_ff.pulse_cnt = cur_ff.pulse_cnt + 32'd1;
      end
      if (cur_ff.mode == flash_seq_pkg::MODE_PROG ?
          cur_ff.pulse_cnt >= CNT_W'(PROG_LIM - 1) :
          cur_ff.pulse_cnt >= CNT_W'(ERASE_LIM - 1)) begin
        nxt_ff.overrun = 1'b1;
      end
    end else begin
      nxt_ff.pulse_cnt = '0;
      nxt_ff.overrun = 1'b0;
    end
    // Latch program data; each write's address replaces the latched address.
    if (i_wr_en && cur_ff.mode == flash_seq_pkg::MODE_IDLE
        && i_flash_write_unlock && permit) begin
      nxt_ff.unit_full = (i_wr_addr[flash_seq_pkg::UNIT_IDX_W-1:0]
                          == {flash_seq_pkg::UNIT_IDX_W{1'b1}});
      nxt_ff.vaddr = i_wr_addr;
    end
    // Dummy write in a verify mode latches the address to check.
    if (i_wr_en && (cur_ff.mode == flash_seq_pkg::MODE_PCHK
                    || cur_ff.mode == flash_seq_pkg::MODE_ECHK)) begin
      nxt_ff.vaddr = i_wr_addr;
    end
    // Sequential walk over latches while programming.
    if (cur_ff.mode == flash_seq_pkg::MODE_PROG && !cur_ff.overrun) begin
      nxt_ff.idx = cur_ff.idx + 5'd1;
    end else begin
      nxt_ff.idx = flash_seq_pkg::IDX_RST;
    end
    // Reads: blocked during program/erase, verify reads use the latched address.
    nxt_ff.rd_pend = 1'b0;
    nxt_ff.rd_chk = 1'b0;
    if (i_rd_en) begin
      if (active_mode(cur_ff.mode)) begin
        nxt_ff.blocked = 1'b1;
      end else begin
        nxt_ff.rd_pend = 1'b1;
        nxt_ff.rd_chk = (cur_ff.mode != flash_seq_pkg::MODE_IDLE);
      end
    end
    if (cur_ff.rd_pend) begin
      nxt_ff.rdata = i_array_rdata;
      nxt_ff.rvalid = 1'b1;
    end
  end

  // One register holds all state except the latch memory; reset values are constants only.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cur_ff <= '{pin_sync: 2'b00, mode: flash_seq_pkg::MODE_IDLE,
                  idx: flash_seq_pkg::IDX_RST, unit_full: 1'b0,
                  vaddr: flash_seq_pkg::ADDR_RST, pulse_cnt: '0,
                  overrun: 1'b0, passes: 16'h0000, guard_clear: 1'b0,
                  rd_pend: 1'b0, rd_chk: 1'b0, blocked: 1'b0,
                  rdata: 16'h0000, rvalid: 1'b0};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Array drive; verify reads come from the latched address.
  assign o_array_rd = nxt_ff.rd_pend;
  assign o_array_addr = (cur_ff.mode == flash_seq_pkg::MODE_IDLE)
                        ? i_rd_addr : cur_ff.vaddr;
  assign o_array_prog = (cur_ff.mode == flash_seq_pkg::MODE_PROG)
                        && !cur_ff.overrun;
  assign o_array_erase = (cur_ff.mode == flash_seq_pkg::MODE_ERASE)
                         && !cur_ff.overrun;
  assign o_array_blocks = (cur_ff.mode == flash_seq_pkg::MODE_ERASE)
                          ? i_block_select_reg : flash_seq_pkg::BLK_RST;
  assign o_latch_data = latch_q;
  assign o_latch_idx = cur_ff.idx;
  assign o_rd_data = cur_ff.rdata;
  assign o_rd_valid = cur_ff.rvalid;
  assign o_rd_blocked = cur_ff.blocked;
  assign o_permit_flag = permit;
  assign o_mode = cur_ff.mode;
  assign o_guard_clear = cur_ff.guard_clear;
  assign o_pulse_overrun = cur_ff.overrun;
  assign o_pass_count = cur_ff.passes;
  assign o_retry_exhausted = (cur_ff.passes >= 16'(RETRY_N));
  assign o_unit_full = cur_ff.unit_full;
endmodule : flash_program_erase_sequencer

// file: design/flash_seq_pkg.sv
// Constants and types shared by the flash program/erase sequencer.
package flash_seq_pkg;
  // Width of the flash byte address.
  localparam int ADDR_W = 16;
  // Verify data are read in 16-bit units.
  localparam int VDATA_W = 16;
  // Programming happens in units of this many bytes.
  localparam int UNIT_BYTES = 32;
  localparam int UNIT_IDX_W = 5;
  // Number of erase blocks selected by the block-select register.
  localparam int BLOCKS = 8;
  // Byte written during a dummy write ahead of a verify read.
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Reset value of the latched verify address.
  localparam logic [15:0] ADDR_RST = 16'h0000;
  // Reset value of the latch read index.
  localparam logic [4:0] IDX_RST = 5'h00;
  // Block value driven to the array outside erase mode.
  localparam logic [7:0] BLK_RST = 8'h00;

  // Array operating modes, one-hot.
  typedef enum logic [4:0] {
    MODE_IDLE = 5'b00001,
    MODE_PROG = 5'b00010,
    MODE_ERASE = 5'b00100,
    MODE_PCHK = 5'b01000,
    MODE_ECHK = 5'b10000
  } mode_type;
endpackage : flash_seq_pkg

// file: design/flash_write_latch.sv
// Latch memory holding the data bytes of one 32-byte programming unit.
`timescale 1ns/100ps
module flash_write_latch #(
  parameter int DEPTH = flash_seq_pkg::UNIT_BYTES,
  parameter int IDX_W = flash_seq_pkg::UNIT_IDX_W
) (
  // Clock.
  input wire logic i_clock,
  // Write port.
  input wire logic i_wr_en,
  input wire logic [IDX_W-1:0] i_wr_idx,
  input wire logic [7:0] i_wr_data,
  // Registered read port.
  input wire logic [IDX_W-1:0] i_rd_idx,
  output logic [7:0] o_rd_data
);
  logic [7:0] mem [DEPTH];

  // Storage has no reset; software always refills all 32 bytes.
  always_ff @(posedge i_clock) begin
    if (i_wr_en) begin
      mem[i_wr_idx] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_idx];
  end
endmodule : flash_write_latch

// file: test/flash_program_erase_sequencer_tb.sv
// Self-checking bench for the flash program/erase sequencer.
`timescale 1ns/100ps
module flash_program_erase_sequencer_tb;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic permit = 1'b0;
  // Control bits come from the bench only, never from array code.
  logic [6:0] ctl = 7'h00;
  // One microsecond of pulse at 200 MHz, and a small retry limit.
  localparam int Z_CYC = 200;
  localparam int RETRY = 10;
  // Original program data kept aside, as software keeps it in RAM.
  logic [7:0] buf_q [32];
  logic [7:0] blk = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] wr_addr = 16'h0000;
  logic [15:0] rd_addr = 16'h0000;
  logic [7:0] wr_data = 8'h00;
  logic [15:0] arr = 16'h0000;
  logic [15:0] base;
  logic [15:0] rdq[$];
  int miscompares = 0;
  int comparisons = 0;
  int blocked_seen = 0;
  int guard_seen = 0;
  wire [15:0] o_array_addr, o_rd_data, o_pass_count;
  wire [7:0] o_array_blocks;
  wire [4:0] o_mode, o_latch_idx;
  wire o_array_prog, o_array_erase, o_rd_valid, o_rd_blocked, o_guard_clear;
  wire o_unit_full, o_pulse_overrun, o_retry_exhausted;
  wire [7:0] o_latch_data;
  flash_program_erase_sequencer #(.RETRY_N(RETRY)) DUT (.i_clock, .i_resetn,
    .i_hardware_write_permit_pin(permit), .i_flash_write_unlock(ctl[6]),
    .i_write_setup(ctl[5]), .i_write_pulse(ctl[4]), .i_write_check(ctl[3]),
    .i_wipe_setup(ctl[2]), .i_wipe_pulse(ctl[1]), .i_wiping_audit(ctl[0]),
    .i_block_select_reg(blk), .i_wr_en(wr_en), .i_wr_addr(wr_addr),
    .i_wr_data(wr_data), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
    .i_array_rdata(arr), .o_array_rd(), .o_array_addr, .o_array_prog,
    .o_array_erase, .o_array_blocks, .o_latch_data, .o_latch_idx,
    .o_rd_data, .o_rd_valid, .o_rd_blocked, .o_permit_flag(), .o_mode,
    .o_guard_clear, .o_pulse_overrun, .o_pass_count,
    .o_retry_exhausted, .o_unit_full);
  // Free-running 200 MHz clock.
  always #2.5 i_clock = ~i_clock;
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask : cyc
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    cyc(1);
    wr_en <= 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input bit blk);
    if (!blk) rdq.push_back(exp);
    rd_en <= 1'b1;
    rd_addr <= a;
    cyc(1);
    rd_en <= 1'b0;
    cyc(4);
  endtask : rd
  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  // Read answers are matched to the oldest note; pulses are counted.
  always @(posedge i_clock) begin
    if (o_rd_blocked === 1'b1) blocked_seen++;
    if (o_guard_clear === 1'b1) guard_seen++;
    if (o_rd_valid === 1'b1) begin
      if (rdq.size() == 0) cmp(16'hdead, 16'h0000);
      else cmp(o_rd_data, rdq.pop_front());
    end
  end
  // Watchdog sized well above the few hundred cycles the sequence needs.
  initial begin
    cyc(5000);
    miscompares++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h7e2d2caa));
    cyc(10);
    i_resetn <= 1'b1;
    cyc(4);
    ctl <= 7'b1110000;
    cyc(4);
    cmp(16'(o_mode), 16'(flash_seq_pkg::MODE_IDLE));
    permit <= 1'b1;
    ctl <= 7'b1000000;
    cyc(4);
    base = {8'($urandom), 3'($urandom), 5'h00};
    for (int i = 0; i < 32; i++) begin
      buf_q[i] = i < 20 ? 8'($urandom) : 8'hff;
      wr(base + 16'(i), buf_q[i]);
    end
    cmp(16'(o_latch_idx), 16'(flash_seq_pkg::IDX_RST));
    cmp(16'(o_unit_full), 16'h0001);
    ctl <= 7'b1100000;
    cyc(2);
    ctl <= 7'b1110000;
    cyc(3);
    cmp(16'(o_mode), 16'(flash_seq_pkg::MODE_PROG));
    cmp(16'(o_array_prog), 16'h0001);
    cmp(16'(o_latch_data), 16'(buf_q[0]));
    rd(base, 16'h0000, 1'b1);
    cmp(16'(blocked_seen), 16'h0001);
    cmp(16'(o_latch_data), 16'(buf_q[5]));
    ctl <= 7'b1100000;
    cyc(2);
    ctl <= 7'b1001000;
    cyc(3);
    cmp(16'(o_mode), 16'(flash_seq_pkg::MODE_PCHK));
    arr <= 16'($urandom);
    wr(base + 16'h0006, 8'hff);
    cmp(o_array_addr, base + 16'h0006);
    rd(base + 16'h0006, arr, 1'b0);
    for (int b = 0; b < 8; b++) begin
      blk <= 8'h01 << b;
      ctl <= 7'b1000100;
      cyc(2);
      ctl <= 7'b1000110;
      cyc(3);
      cmp(16'(o_mode), 16'(flash_seq_pkg::MODE_ERASE));
      cmp(16'(o_array_blocks), 16'h0001 << b);
      ctl <= 7'b1000100;
      cyc(2);
    end
    blk <= 8'h03;
    ctl <= 7'b1000110;
    cyc(4);
    cmp(16'(o_array_erase), 16'h0000);
    // A pulse held past its limit must be cut by the design.
    ctl <= 7'b1100000;
    cyc(2);
    ctl <= 7'b1110000;
    cyc(Z_CYC);
    cmp(16'(o_array_prog), 16'h0001);
    cyc(2);
    cmp(16'(o_pulse_overrun), 16'h0001);
    cmp(16'(o_array_prog), 16'h0000);
    cmp(16'(o_retry_exhausted), 16'h0000);
    ctl <= 7'b1100000;
    cyc(2);
    cmp(16'(o_retry_exhausted), 16'h0001);
    ctl <= 7'b1000001;
    cyc(3);
    cmp(16'(o_mode), 16'(flash_seq_pkg::MODE_ECHK));
    arr <= 16'hffff;
    wr(base, 8'hff);
    rd(base, 16'hffff, 1'b0);
    cmp(16'(guard_seen), 16'h000a);
    cmp(o_pass_count, 16'h000a);
    cmp(16'(rdq.size()), 16'h0000);
    stop_test();
  end
endmodule : flash_program_erase_sequencer_tb

// file: test/flash_seq_chk.sv
// Port-level checker for the flash program/erase sequencer.
`timescale 1ns/100ps
module flash_seq_chk (
  // Watched ports.
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_flash_write_unlock,
  input wire logic i_write_setup,
  input wire logic i_write_pulse,
  input wire logic i_write_check,
  input wire logic i_wipe_setup,
  input wire logic i_wipe_pulse,
  input wire logic [7:0] i_block_select_reg,
  input wire logic i_wr_en,
  input wire logic [15:0] i_wr_addr,
  input wire logic i_rd_en,
  input wire logic [15:0] i_array_rdata,
  input wire logic o_array_rd,
  input wire logic o_array_prog,
  input wire logic o_array_erase,
  input wire logic o_pulse_overrun,
  input wire logic [15:0] o_pass_count,
  input wire logic [15:0] o_rd_data,
  input wire logic o_rd_valid,
  input wire logic o_rd_blocked,
  input wire logic o_permit_flag,
  input wire logic [4:0] o_mode,
  input wire logic o_guard_clear,
  input wire logic [4:0] o_latch_idx,
  input wire logic o_unit_full
);
  // All checks share one clock and the reset of its domain.
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  logic en;
  assign en = o_permit_flag && i_flash_write_unlock;
  property p_no_permit;
    !o_permit_flag |=> o_mode == flash_seq_pkg::MODE_IDLE;
  endproperty
  a_no_permit: assert property (p_no_permit) else $error("mode left idle");
  property p_prog;
    en && i_write_setup && i_write_pulse |=> o_mode == flash_seq_pkg::MODE_PROG;
  endproperty
  a_prog: assert property (p_prog) else $error("program mode missed");
  property p_erase;
    en && i_wipe_setup && i_wipe_pulse && !i_write_setup && !i_write_pulse
      && !i_write_check && $onehot(i_block_select_reg)
      |=> o_mode == flash_seq_pkg::MODE_ERASE;
  endproperty
  a_erase: assert property (p_erase) else $error("erase mode missed");
  property p_refuse;
    $countones(i_block_select_reg) != 1 |=> o_mode != flash_seq_pkg::MODE_ERASE;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad block erase");
  property p_blocked;
    i_rd_en && (o_mode == flash_seq_pkg::MODE_PROG
      || o_mode == flash_seq_pkg::MODE_ERASE) |=> o_rd_blocked ##1 !o_rd_valid;
  endproperty
  a_blocked: assert property (p_blocked) else $error("read not blocked");
  property p_verify_rd;
    i_rd_en && o_mode == flash_seq_pkg::MODE_PCHK |-> o_array_rd ##2
      (o_rd_valid && o_rd_data == $past(i_array_rdata));
  endproperty
  a_verify_rd: assert property (p_verify_rd) else $error("verify read");
  property p_latch;
    i_wr_en && en && o_mode == flash_seq_pkg::MODE_IDLE
      |=> o_latch_idx == flash_seq_pkg::IDX_RST
        && o_unit_full == ($past(i_wr_addr[4:0]) == 5'h1f);
  endproperty
  a_latch: assert property (p_latch) else $error("latch index");
  property p_guard;
    o_mode == flash_seq_pkg::MODE_PROG ##1 o_mode == flash_seq_pkg::MODE_IDLE
      |-> ##[0:1] o_guard_clear;
  endproperty
  a_guard: assert property (p_guard) else $error("guard not cleared");
  property p_guard_pulse;
    o_guard_clear |=> !o_guard_clear;
  endproperty
  a_guard_pulse: assert property (p_guard_pulse) else $error("guard pulse long");
  // An overrun must cut the array pulse at once.
  property p_overrun;
    o_pulse_overrun |-> !o_array_prog && !o_array_erase;
  endproperty
  a_overrun: assert property (p_overrun) else $error("pulse not cut");
  // Every exit from a pulse mode counts exactly one pass.
  property p_pass_step;
    o_guard_clear |-> o_pass_count == 16'($past(o_pass_count) + 16'd1);
  endproperty
  a_pass_step: assert property (p_pass_step) else $error("pass count");
endmodule : flash_seq_chk

bind flash_program_erase_sequencer flash_seq_chk u_chk (.i_clock, .i_resetn,
  .i_flash_write_unlock, .i_write_setup, .i_write_pulse, .i_write_check,
  .i_wipe_setup, .i_wipe_pulse, .i_block_select_reg, .i_wr_en, .i_wr_addr,
  .i_rd_en, .i_array_rdata, .o_array_rd, .o_array_prog, .o_array_erase,
  .o_pulse_overrun, .o_pass_count, .o_rd_data, .o_rd_valid,
  .o_rd_blocked, .o_permit_flag, .o_mode, .o_guard_clear, .o_latch_idx,
  .o_unit_full);
